// ===== audio_serial_irq_sync_loopback.sv
// Audio serial controller: interrupt flags, clock domain crossing, two serializers with loop-back
`timescale 1ns/10ps
`include "audio_serial_regs.svh"

module audio_serial_irq_sync_loopback
  import audio_serial_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire bus_req_s   busReq,
  output bus_rsp_s        busRsp,
  output logic            irqOut,
  input  wire logic       serialGenericClock,
  input  wire logic [1:0] sdIn,
  output logic      [1:0] sdOut,
  output logic      [1:0] sdOe
);

  // ------------------------------------------------------------
  // Bus domain registers
  // ------------------------------------------------------------
  bus_state_e  state;
  logic [7:0]  mainControl;
  logic [31:0] clockUnitControl [2];
  logic [31:0] serializerControl [2];
  logic [31:0] sampleHolding [2];
  logic [15:0] irqEnable;
  logic [15:0] irqFlags;
  logic [15:0] crossPending;
  logic        ctrlReq;
  logic [1:0]  dataReq;
  logic [6:0]  busSync1;
  logic [6:0]  busSync2;
  logic [6:0]  busSyncPrev;

  // ------------------------------------------------------------
  // Link domain registers
  // ------------------------------------------------------------
  logic        rstSyncA;
  logic        rstSyncB;
  logic [2:0]  linkSync1;
  logic [2:0]  linkSync2;
  logic [2:0]  linkSyncPrev;
  logic [3:0]  cfgSync1;
  logic [3:0]  cfgSync2;
  logic [1:0]  pinSync1;
  logic [1:0]  pinSync2;
  logic [7:0]  linkCtrl;
  logic        ctrlAck;
  logic [1:0]  dataAck;
  logic [1:0]  wordEvt;
  logic [1:0]  starveEvt;
  logic [31:0] shiftReg [2];
  logic [31:0] txHold [2];
  logic [31:0] rxWord [2];
  logic [4:0]  bitCnt [2];
  logic [1:0]  txFull;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire        access     = busReq.sel & busReq.enable & (state == BUS_IDLE);
  wire        wr         = access & busReq.write;
  wire        rd         = access & ~busReq.write;
  wire [31:0] wdata      = busReq.wdata;
  wire        hitMain    = busReq.addr == `OFF_MAIN_CONTROL;
  wire        hitClk0    = busReq.addr == `OFF_CLOCK_UNIT0;
  wire        hitClk1    = busReq.addr == `OFF_CLOCK_UNIT1;
  wire        hitEnClr   = busReq.addr == `OFF_IRQ_EN_CLEAR;
  wire        hitEnSet   = busReq.addr == `OFF_IRQ_EN_SET;
  wire        hitFlags   = busReq.addr == `OFF_IRQ_FLAGS;
  wire        hitPend    = busReq.addr == `OFF_CROSS_PENDING;
  wire        hitSer0    = busReq.addr == `OFF_SERIALIZER0;
  wire        hitSer1    = busReq.addr == `OFF_SERIALIZER1;
  wire [1:0]  hitData    = {busReq.addr == `OFF_SAMPLE1, busReq.addr == `OFF_SAMPLE0};
  wire        anyHit     = hitMain | hitClk0 | hitClk1 | hitEnClr | hitEnSet | hitFlags | hitPend
                           | hitSer0 | hitSer1 | (|hitData);
  wire [1:0]  txMode     = {serializerControl[1][1:0] == `SER_MODE_TX, serializerControl[0][1:0] == `SER_MODE_TX};
  wire [1:0]  loopSel    = {serializerControl[1][`SER_LOOPBACK], serializerControl[0][`SER_LOOPBACK]};
  wire        blockOn    = mainControl[`MAIN_ENABLE];

  // ------------------------------------------------------------
  // Crossing events arriving from the link domain
  // ------------------------------------------------------------
  wire [6:0]  busPulse     = busSync2 ^ busSyncPrev;
  wire        ctrlDone     = busPulse[0];
  wire [1:0]  dataDone     = busPulse[2:1];
  wire [1:0]  wordArrive   = busPulse[4:3];
  wire [1:0]  starveArrive = busPulse[6:5];

  // ------------------------------------------------------------
  // Synchronised operations and their errors
  // ------------------------------------------------------------
  wire        ctrlBusy     = |crossPending[5:0];
  wire        ctrlErr      = wr & hitMain & ctrlBusy;
  wire        ctrlWrOk     = wr & hitMain & ~ctrlBusy;
  wire        softReset    = ctrlWrOk & wdata[`MAIN_SOFT_RESET];
  wire [5:0]  ctrlChanged  = {wdata[5:1] ^ mainControl[5:1], 1'b0};
  wire [5:0]  ctrlBusySet  = softReset ? 6'h01 : ctrlChanged;
  wire        ctrlLaunch   = ctrlWrOk & (|ctrlBusySet);
  wire [1:0]  dataSyncNeed = hitData & ((~txMode & {2{rd}}) | (txMode & {2{wr}}));
  wire [1:0]  dataErr      = dataSyncNeed & crossPending[`PEND_DATA +: 2];
  wire [1:0]  dataLaunch   = dataSyncNeed & ~crossPending[`PEND_DATA +: 2];
  wire [1:0]  dataWrOk     = hitData & {2{wr}} & ~dataErr;
  wire [1:0]  dataRdOk     = hitData & {2{rd}} & ~dataErr;
  wire        busErr       = (access & ~anyHit) | ctrlErr | (|dataErr);
  wire        clkWrOk      = wr & ~blockOn;
  wire [7:0]  ctrlToLink   = {mainControl[7:1], crossPending[`MAIN_SOFT_RESET]};

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  logic [15:0] next_crossPending;
  logic [15:0] next_irqEnable;
  logic [15:0] next_irqFlags;
  logic [15:0] flagSet;
  logic [15:0] flagClr;
  logic [31:0] readMux;

  always_comb
  begin
    next_crossPending = crossPending;
    next_crossPending[5:0] = ctrlDone ? 6'h00 : (crossPending[5:0] | (ctrlLaunch ? ctrlBusySet : 6'h00));
    next_crossPending[`PEND_DATA +: 2] = (crossPending[`PEND_DATA +: 2] | dataLaunch) & ~dataDone;
  end

  always_comb
  begin
    next_irqEnable = irqEnable;
    if (wr & hitEnSet)
      next_irqEnable = irqEnable | (wdata[15:0] & `IRQ_MASK);
    else if (wr & hitEnClr)
      next_irqEnable = irqEnable & ~(wdata[15:0] & `IRQ_MASK);
  end

  always_comb
  begin
    flagSet = 16'h0000;
    flagClr = (wr & hitFlags) ? (wdata[15:0] & `IRQ_MASK) : 16'h0000;
    for (int m = 0; m < 2; m++)
    begin
      flagSet[`IRQ_RX_AVAILABLE + m] = wordArrive[m] & ~txMode[m];
      flagSet[`IRQ_RX_OVERFLOW + m]  = wordArrive[m] & ~txMode[m] & irqFlags[`IRQ_RX_AVAILABLE + m];
      flagSet[`IRQ_TX_EMPTY + m]     = wordArrive[m] & txMode[m];
      flagSet[`IRQ_TX_STARVED + m]   = starveArrive[m];
      flagClr[`IRQ_RX_AVAILABLE + m] = flagClr[`IRQ_RX_AVAILABLE + m] | (dataRdOk[m] & ~txMode[m]);
      flagClr[`IRQ_TX_EMPTY + m]     = flagClr[`IRQ_TX_EMPTY + m] | (dataWrOk[m] & txMode[m]);
    end
    // Hardware events win over software clears so none is lost
    next_irqFlags = (irqFlags & ~flagClr) | flagSet;
  end

  always_comb
  begin
    readMux = 32'h00000000;
    if (hitMain)
      readMux = {24'h000000, ctrlToLink};
    else if (hitClk0)
      readMux = clockUnitControl[0];
    else if (hitClk1)
      readMux = clockUnitControl[1];
    else if (hitEnClr | hitEnSet)
      readMux = {16'h0000, irqEnable};
    else if (hitFlags)
      readMux = {16'h0000, irqFlags};
    else if (hitPend)
      readMux = {16'h0000, crossPending};
    else if (hitSer0)
      readMux = serializerControl[0];
    else if (hitSer1)
      readMux = serializerControl[1];
    else if (hitData[0])
      readMux = sampleHolding[0];
    else if (hitData[1])
      readMux = sampleHolding[1];
  end

  // ------------------------------------------------------------
  // Bus slave answer, one wait state
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state  <= BUS_IDLE;
      busRsp <= '0;
    end
    else if (access)
    begin
      state         <= BUS_REPLY;
      busRsp.ready  <= 1'b1;
      busRsp.slverr <= busErr;
      busRsp.rdata  <= busErr ? 32'h00000000 : readMux;
    end
    else
    begin
      state  <= BUS_IDLE;
      busRsp <= '0;
    end
  end

  // ------------------------------------------------------------
  // Control, enables and flags
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn || softReset)
    begin
      mainControl          <= `MAIN_CONTROL_RST;
      clockUnitControl[0]  <= `CLOCK_UNIT_RST;
      clockUnitControl[1]  <= `CLOCK_UNIT_RST;
      serializerControl[0] <= `SERIALIZER_RST;
      serializerControl[1] <= `SERIALIZER_RST;
      irqEnable            <= `IRQ_RST;
      irqFlags             <= `IRQ_RST;
    end
    else
    begin
      if (ctrlWrOk)
        mainControl <= wdata[7:0] & `MAIN_CONTROL_MASK & 8'hFE;
      if (clkWrOk & hitClk0)
        clockUnitControl[0] <= wdata & `CLOCK_UNIT_MASK;
      if (clkWrOk & hitClk1)
        clockUnitControl[1] <= wdata & `CLOCK_UNIT_MASK;
      if (wr & hitSer0)
        serializerControl[0] <= wdata & `SERIALIZER_MASK;
      if (wr & hitSer1)
        serializerControl[1] <= wdata & `SERIALIZER_MASK;
      irqEnable <= next_irqEnable;
      irqFlags  <= next_irqFlags;
    end
  end

  // Crossing state survives a soft reset so a handshake in flight is never torn
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      crossPending <= `PEND_RST;
      ctrlReq      <= 1'b0;
      dataReq      <= 2'b00;
      irqOut       <= 1'b0;
    end
    else
    begin
      crossPending <= next_crossPending;
      ctrlReq      <= ctrlReq ^ ctrlLaunch;
      dataReq      <= dataReq ^ dataLaunch;
      irqOut       <= ~softReset & (|(irqFlags & irqEnable));
    end
  end

  always_ff @(posedge mclk)
  begin
    for (int m = 0; m < 2; m++)
    begin
      if (!resetn || softReset)
        sampleHolding[m] <= `SAMPLE_RST;
      else if (dataWrOk[m])
        sampleHolding[m] <= wdata;
      else if (wordArrive[m] & ~txMode[m])
        sampleHolding[m] <= rxWord[m];
    end
  end

  // ------------------------------------------------------------
  // Toggle synchronisers into the bus domain
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      busSync1    <= 7'h00;
      busSync2    <= 7'h00;
      busSyncPrev <= 7'h00;
    end
    else
    begin
      busSync1    <= {starveEvt, wordEvt, dataAck, ctrlAck};
      busSync2    <= busSync1;
      busSyncPrev <= busSync2;
    end
  end

  // ------------------------------------------------------------
  // Link domain: reset, request and configuration synchronisers
  // ------------------------------------------------------------
  wire        linkReset  = ~rstSyncB;
  wire [2:0]  linkPulse  = linkSync2 ^ linkSyncPrev;
  wire [1:0]  linkTx     = cfgSync2[1:0];
  wire [1:0]  linkLoop   = cfgSync2[3:2];
  wire [1:0]  active     = {2{linkCtrl[`MAIN_ENABLE] & ~linkCtrl[`MAIN_SOFT_RESET]}}
                           & linkCtrl[`MAIN_CLOCK_UNIT +: 2] & linkCtrl[`MAIN_SERIALIZER +: 2];
  // Loop-back takes the other serializer's driven bit in place of the pin
  wire [1:0]  rxBit      = {linkLoop[1] ? sdOut[0] : pinSync2[1],
                            linkLoop[0] ? sdOut[1] : pinSync2[0]};

  always_ff @(posedge serialGenericClock)
  begin
    rstSyncA <= resetn;
    rstSyncB <= rstSyncA;
  end

  // Serializer configuration is quasi-static: software disables before changing it
  always_ff @(posedge serialGenericClock)
  begin
    if (linkReset)
    begin
      linkSync1    <= 3'h0;
      linkSync2    <= 3'h0;
      linkSyncPrev <= 3'h0;
      cfgSync1     <= 4'h0;
      cfgSync2     <= 4'h0;
      pinSync1     <= 2'b00;
      pinSync2     <= 2'b00;
    end
    else
    begin
      linkSync1    <= {dataReq, ctrlReq};
      linkSync2    <= linkSync1;
      linkSyncPrev <= linkSync2;
      cfgSync1     <= {loopSel, txMode};
      cfgSync2     <= cfgSync1;
      pinSync1     <= sdIn;
      pinSync2     <= pinSync1;
    end
  end

  always_ff @(posedge serialGenericClock)
  begin
    if (linkReset)
    begin
      linkCtrl <= `MAIN_CONTROL_RST;
      ctrlAck  <= 1'b0;
    end
    else if (linkPulse[0])
    begin
      linkCtrl <= ctrlToLink;
      ctrlAck  <= ~ctrlAck;
    end
  end

  // ------------------------------------------------------------
  // Serializers: 32-bit words, most significant bit first
  // ------------------------------------------------------------
  always_ff @(posedge serialGenericClock)
  begin
    for (int m = 0; m < 2; m++)
    begin
      if (linkReset)
      begin
        dataAck[m]   <= 1'b0;
        wordEvt[m]   <= 1'b0;
        starveEvt[m] <= 1'b0;
        txFull[m]    <= 1'b0;
        bitCnt[m]    <= 5'h00;
        shiftReg[m]  <= 32'h00000000;
        txHold[m]    <= 32'h00000000;
        rxWord[m]    <= 32'h00000000;
        sdOut[m]     <= 1'b0;
        sdOe[m]      <= 1'b0;
      end
      else
      begin
        sdOut[m] <= shiftReg[m][31];
        sdOe[m]  <= active[m] & linkTx[m] & ~linkLoop[m];
        if (!active[m])
        begin
          bitCnt[m] <= 5'h00;
          if (linkCtrl[`MAIN_SOFT_RESET])
            txFull[m] <= 1'b0;
        end
        else if (bitCnt[m] != 5'h1F)
        begin
          bitCnt[m]   <= bitCnt[m] + 5'h01;
          shiftReg[m] <= {shiftReg[m][30:0], linkTx[m] ? 1'b0 : rxBit[m]};
        end
        else if (!linkTx[m])
        begin
          bitCnt[m]   <= 5'h00;
          rxWord[m]   <= {shiftReg[m][30:0], rxBit[m]};
          shiftReg[m] <= 32'h00000000;
          wordEvt[m]  <= ~wordEvt[m];
        end
        else if (txFull[m])
        begin
          bitCnt[m]   <= 5'h00;
          shiftReg[m] <= txHold[m];
          txFull[m]   <= 1'b0;
          wordEvt[m]  <= ~wordEvt[m];
        end
        else
        begin
          bitCnt[m]    <= 5'h00;
          shiftReg[m]  <= 32'h00000000;
          starveEvt[m] <= ~starveEvt[m];
        end
        // A new word arriving as the old one loads stays pending
        if (linkPulse[1 + m])
        begin
          dataAck[m] <= ~dataAck[m];
          if (linkTx[m])
          begin
            txHold[m] <= sampleHolding[m];
            txFull[m] <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  irq_raise_a: assert property (@(posedge mclk) disable iff (!resetn)
    (|(irqFlags & irqEnable)) && !softReset |=> irqOut)
    else $error("request missing with flag and enable set");
  irq_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
    !(|(irqFlags & irqEnable)) |=> !irqOut)
    else $error("request without enabled flag");
  enable_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr && hitEnSet |=> ((irqEnable & $past(wdata[15:0]) & `IRQ_MASK) == ($past(wdata[15:0]) & `IRQ_MASK)))
    else $error("enable set ignored");
  enable_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr && hitEnClr && !softReset |=> ((irqEnable & $past(wdata[15:0])) == 16'h0000)
      && ((irqEnable & ~$past(wdata[15:0])) == ($past(irqEnable) & ~$past(wdata[15:0]))))
    else $error("enable clear wrong");
  busy_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
    ctrlLaunch |=> (crossPending[5:0] == $past(ctrlBusySet)))
    else $error("busy not raised at issue");
  busy_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(crossPending[`PEND_DATA]) |-> ##[1:80] !crossPending[`PEND_DATA])
    else $error("data crossing never completes");
  busy_error_a: assert property (@(posedge mclk) disable iff (!resetn)
    access && hitMain && busReq.write && ctrlBusy |=> busRsp.ready && busRsp.slverr)
    else $error("no bus error while busy");
  soft_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
    softReset |=> mainControl == `MAIN_CONTROL_RST && irqEnable == `IRQ_RST && crossPending[0])
    else $error("soft reset did not clear");
  enable_guard_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr && hitClk0 && blockOn && !softReset |=> $stable(clockUnitControl[0]))
    else $error("clock unit written while enabled");
  flag_wins_a: assert property (@(posedge mclk) disable iff (!resetn || softReset)
    (flagSet & flagClr) != 16'h0000 |=> (irqFlags & $past(flagSet)) == $past(flagSet))
    else $error("set lost to clear");
  loop_pin_a: assert property (@(posedge serialGenericClock) disable iff (linkReset)
    linkLoop[0] |=> !sdOe[0])
    else $error("looped serializer drives its pin");

endmodule

// ===== audio_serial_regs.svh
// Register offsets, field positions, reset values and masks of the audio serial control block
`ifndef AUDIO_SERIAL_REGS_SVH
`define AUDIO_SERIAL_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFF_MAIN_CONTROL   8'h00
`define OFF_CLOCK_UNIT0    8'h04
`define OFF_CLOCK_UNIT1    8'h08
`define OFF_IRQ_EN_CLEAR   8'h0C
`define OFF_IRQ_EN_SET     8'h10
`define OFF_IRQ_FLAGS      8'h14
`define OFF_CROSS_PENDING  8'h18
`define OFF_SERIALIZER0    8'h20
`define OFF_SERIALIZER1    8'h24
`define OFF_SAMPLE0        8'h30
`define OFF_SAMPLE1        8'h34

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MAIN_SOFT_RESET    0
`define MAIN_ENABLE        1
`define MAIN_CLOCK_UNIT    2
`define MAIN_SERIALIZER    4
`define PEND_DATA          8
`define IRQ_RX_AVAILABLE   0
`define IRQ_RX_OVERFLOW    4
`define IRQ_TX_EMPTY       8
`define IRQ_TX_STARVED     12
`define SER_LOOPBACK       26
`define SER_MODE_TX        2'h1

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define MAIN_CONTROL_RST   8'h00
`define CLOCK_UNIT_RST     32'h00000000
`define SERIALIZER_RST     32'h00000000
`define SAMPLE_RST         32'h00000000
`define IRQ_RST            16'h0000
`define PEND_RST           16'h0000
`define MAIN_CONTROL_MASK  8'h3F
`define CLOCK_UNIT_MASK    32'hFFFD19FF
`define SERIALIZER_MASK    32'h07FFF7BF
`define IRQ_MASK           16'h3333

`endif

// ===== audio_serial_pkg.sv
// Types shared by the audio serial control block
package audio_serial_pkg;

  // ------------------------------------------------------------
  // Peripheral bus request and answer
  // ------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } bus_rsp_s;

  // ------------------------------------------------------------
  // Bus slave phase
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE  = 1'b0,
    BUS_REPLY = 1'b1
  } bus_state_e;

endpackage

// ===== audio_codec_model.sv
// Far-side audio device model driving the serial data pins
`timescale 1ns/10ps

module audio_codec_model
(
  input  wire logic       lclk,
  input  wire logic [1:0] sdOut,
  input  wire logic [1:0] sdOe,
  output logic      [1:0] sdIn
);
  // ------------------------------------------------------------
  // Pin resolution
  // ------------------------------------------------------------
  // The codec streams all-ones words, so any word taken from a looped pin shows up as a mismatch
  logic codecBit;

  always @(negedge lclk)
    codecBit <= 1'b1;

  assign sdIn[0] = sdOe[0] ? sdOut[0] : codecBit;
  assign sdIn[1] = sdOe[1] ? sdOut[1] : codecBit;
endmodule

// ===== audio_serial_irq_sync_loopback_tb_top.sv
// Self-checking testbench of the audio serial control block
`timescale 1ns/10ps
`include "audio_serial_regs.svh"
`define CHK(s, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", s, e, a); end end

module audio_serial_irq_sync_loopback_tb_top;
  import audio_serial_pkg::*;
  logic       mclk   = 1'b0;
  logic       resetn = 1'b0;
  logic       lclk   = 1'b0;
  bus_req_s   busReq = '0;
  bus_rsp_s   busRsp;
  logic       irqOut;
  logic [1:0] sdIn;
  logic [1:0] sdOut;
  logic [1:0] sdOe;
  logic [31:0] rd;
  logic       err;
  int         n_fail = 0;
  int         checked = 0;

  always #10 mclk = ~mclk;
  // Offset start keeps the link clock out of phase with the bus clock
  initial
  begin
    #3;
    forever #80 lclk = ~lclk;
  end

  audio_serial_irq_sync_loopback audio_serial_irq_sync_loopback_i (.mclk(mclk), .resetn(resetn), .busReq(busReq),
    .busRsp(busRsp), .irqOut(irqOut), .serialGenericClock(lclk), .sdIn(sdIn), .sdOut(sdOut), .sdOe(sdOe));
  audio_codec_model audio_codec_model_i (.lclk(lclk), .sdOut(sdOut), .sdOe(sdOe), .sdIn(sdIn));

  // ------------------------------------------------------------
  // Bus access and polling
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    busReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    busReq.enable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (busRsp.ready !== 1'b1 && n < 8);
    rd = busRsp.rdata;
    err = busRsp.slverr;
    busReq <= '0;
    if (n >= 8) `CHK("ready", 1'b1, 1'b0)
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    repeat (900)
    begin
      acc(1'b0, a, 32'h0);
      if ((rd & m) === (a == `OFF_CROSS_PENDING ? 32'h0 : m)) break;
    end
    `CHK("poll", (a == `OFF_CROSS_PENDING ? 32'h0 : m), rd & m)
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    acc(1'b1, 8'h1C, 32'h1);
    `CHK("unmapped", 1'b1, err)
    acc(1'b1, `OFF_IRQ_EN_SET, 32'h0001);
    acc(1'b1, `OFF_IRQ_EN_SET, 32'h0010);
    acc(1'b0, `OFF_IRQ_EN_SET, 32'h0);
    `CHK("enable set", 32'h0011, rd)
    acc(1'b1, `OFF_IRQ_EN_CLEAR, 32'h0011);
    acc(1'b0, `OFF_IRQ_EN_CLEAR, 32'h0);
    `CHK("enable clear", 32'h0, rd)
    $display("test regs done");
  endtask

  task automatic t_sync(input logic [31:0] v);
    acc(1'b1, `OFF_MAIN_CONTROL, v);
    acc(1'b0, `OFF_CROSS_PENDING, 32'h0);
    `CHK("busy bits", 32'h3E, rd & 32'h3E)
    acc(1'b1, `OFF_MAIN_CONTROL, v);
    `CHK("busy error", 1'b1, err)
    poll(`OFF_CROSS_PENDING, 32'h3F);
    $display("test sync done");
  endtask

  task automatic t_loop;
    acc(1'b1, `OFF_SERIALIZER0, 32'h04000000);
    acc(1'b1, `OFF_SERIALIZER1, 32'h00000001);
    t_sync(32'h3E);
    poll(`OFF_IRQ_FLAGS, 32'h2011);
    `CHK("loop enables", 2'b10, sdOe)
    `CHK("loop pins", 2'b00, sdOut)
    acc(1'b1, `OFF_CLOCK_UNIT0, 32'hFFFFFFFF);
    acc(1'b0, `OFF_CLOCK_UNIT0, 32'h0);
    `CHK("clock unit locked", 32'h0, rd)
    acc(1'b0, `OFF_SAMPLE0, 32'h0);
    `CHK("loop data", 32'h0, rd)
    `CHK("irq idle", 1'b0, irqOut)
    acc(1'b1, `OFF_IRQ_EN_SET, 32'h0010);
    // The request is registered, so it settles one edge after the access
    @(posedge mclk);
    `CHK("irq on", 1'b1, irqOut)
    acc(1'b1, `OFF_IRQ_EN_CLEAR, 32'h0010);
    @(posedge mclk);
    `CHK("irq masked", 1'b0, irqOut)
    acc(1'b1, `OFF_IRQ_EN_SET, 32'h0010);
    acc(1'b1, `OFF_IRQ_FLAGS, 32'h0010);
    @(posedge mclk);
    `CHK("irq flag clear", 1'b0, irqOut)
    acc(1'b1, `OFF_SAMPLE1, 32'hA5A5A5A5);
    acc(1'b0, `OFF_CROSS_PENDING, 32'h0);
    `CHK("data busy", 32'h200, rd & 32'h200)
    acc(1'b1, `OFF_SAMPLE1, 32'h0);
    `CHK("data busy error", 1'b1, err)
    acc(1'b0, `OFF_SAMPLE1, 32'h0);
    `CHK("data kept", 32'hA5A5A5A5, rd)
    poll(`OFF_IRQ_FLAGS, 32'h0200);
    t_sync(32'h00);
    acc(1'b1, `OFF_CLOCK_UNIT0, 32'hFFFFFFFF);
    acc(1'b0, `OFF_CLOCK_UNIT0, 32'h0);
    `CHK("clock unit open", 32'hFFFD19FF, rd)
    acc(1'b1, `OFF_SERIALIZER0, 32'h0);
    t_sync(32'h3E);
    poll(`OFF_IRQ_FLAGS, 32'h0001);
    acc(1'b0, `OFF_SAMPLE0, 32'h0);
    poll(`OFF_IRQ_FLAGS, 32'h0001);
    acc(1'b0, `OFF_SAMPLE0, 32'h0);
    `CHK("pin data", 32'hFFFFFFFF, rd)
    $display("test loop done");
  endtask

  task automatic t_soft_reset_bit;
    acc(1'b1, `OFF_MAIN_CONTROL, 32'h3F);
    poll(`OFF_CROSS_PENDING, 32'h3F);
    acc(1'b0, `OFF_MAIN_CONTROL, 32'h0);
    `CHK("main after reset", 32'h0, rd)
    acc(1'b0, `OFF_SERIALIZER1, 32'h0);
    `CHK("ser after reset", 32'h0, rd)
    acc(1'b0, `OFF_IRQ_EN_SET, 32'h0);
    `CHK("enables after reset", 32'h0, rd)
    acc(1'b0, `OFF_CLOCK_UNIT0, 32'h0);
    `CHK("clock unit after reset", 32'h0, rd)
    $display("test soft reset done");
  endtask

  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset covers one link edge; the wait after release lets the link synchroniser settle
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (30) @(posedge mclk);
    t_regs;
    t_loop;
    t_soft_reset_bit;
    results;
  end

  initial
  begin
    #1500000;
    n_fail++;
    results;
  end
endmodule
